/* dv/tb.sv */
// self-checking bench for the board config block
`timescale 1ns/100ps
`include "vbc_defs.svh"
module tb
   import vbc_pkg::*;
;
   // clock, resets, jumpers, function code
   logic clk, rst_n, sysrst_n, ext_j, fail_j;
   // privilege strap level and open-drain fail data
   logic strap, sfo;
   logic [2:0] fc_a, fc_b;
   // host bus
   logic reg_wr, reg_supv;
   logic [9:0] reg_addr;
   vbc_byte_type reg_wdata;
   // design outputs
   logic soe, grn, red, lr, priv, ext, role_a, role_b, dir_a, dir_b;
   vbc_am_type am_a, am_b;
   // outputs packed for comparison
   wire [9:0] st = {grn, red, soe, lr, priv, ext, role_a, role_b, dir_a, dir_b};
   // mismatch and comparison counts
   int fails, n_tests;
   vbc_board_config #(.LMR_HOLD_CYCLES(16)) uut (
      .MCLK(clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_SUPV(reg_supv), .SYSRESET_N(sysrst_n),
      .EXTENDED_ADDRESS_JUMPER(ext_j), .FAIL_LINE_JUMPER(fail_j),
      .MODIFIER_JUMPER_ONE(1'b1), .MODIFIER_JUMPER_TWO(1'b0), .MODIFIER_JUMPER_THREE(1'b1),
      .PRIVILEGE_STRAP(strap), .FUNC_CODE_A(fc_a), .FUNC_CODE_B(fc_b), .SYSFAIL_OUT(sfo),
      .SYSFAIL_OE(soe), .LED_GREEN(grn), .LED_RED(red), .LOCAL_RESET(lr),
      .PRIVILEGE_ACCESS_SELECT(priv), .EXTENDED_ADDRESS_MODE(ext), .AM_CODE_A(am_a),
      .AM_CODE_B(am_b), .BUS_CONTROLLER_ROLE_A(role_a), .BUS_CONTROLLER_ROLE_B(role_b),
      .DIRECTION_A(dir_a), .DIRECTION_B(dir_b)
   );
   vbc_host_model u_host (
      .clk(clk), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_supv(reg_supv)
   );
   ////////////////////////////////////////
   // 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // compare one value and count it
   task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // wait n edges, then let updates settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   // wait for the local reset line to drop, bounded
   task automatic wait_low();
      for (int i = 0; i < 64 && lr !== 1'b0; i++)
         cyc(1);
      if (lr !== 1'b0)
      begin
         fails++;
         finish_test();
      end
   endtask : wait_low
   // counts and verdict
   task automatic finish_test();
      $display("fails %0d n_tests %0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : finish_test
   // main sequence
   initial
   begin
      fails = 0;
      n_tests = 0;
      rst_n = 1'b0;
      sysrst_n = 1'b1;
      ext_j = 1'b1;
      fail_j = 1'b1;
      fc_a = 3'h5;
      fc_b = 3'h2;
      strap = 1'b1;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      chk("state", st, 10'h1a0);
      chk("am_a", 10'(am_a), 10'h02d);
      chk("am_b", 10'(am_b), 10'h02a);
      // user cycle refused while supervisor only
      u_host.wr(`VBC_OFF_CTRL_A, 8'h08, 1'b0);
      cyc(2);
      chk("state", st, 10'h1a0);
      // fail, privilege, extended bits from port a
      u_host.wr(`VBC_OFF_CTRL_A, 8'h1c, 1'b1);
      cyc(2);
      chk("state", st, 10'h230);
      chk("am_a", 10'(am_a), 10'h00d);
      // jumper out, new function code
      @(posedge clk);
      ext_j <= 1'b0;
      fc_a <= 3'h3;
      cyc(3);
      chk("am_a", 10'(am_a), 10'h02b);
      // unmapped offset ignored
      u_host.wr(10'h106, 8'h00, 1'b1);
      cyc(2);
      chk("state", st, 10'h220);
      // port b: own role bit, shared board bits
      u_host.wr(`VBC_OFF_CTRL_B, 8'h01, 1'b1);
      cyc(2);
      chk("state", st, 10'h184);
      u_host.wr(`VBC_OFF_CTRL_B, 8'h09, 1'b0);
      cyc(2);
      chk("state", st, 10'h204);
      // fail jumper out: line never pulled
      @(posedge clk);
      fail_j <= 1'b0;
      u_host.wr(`VBC_OFF_CTRL_B, 8'h01, 1'b0);
      cyc(2);
      chk("state", st, 10'h104);
      u_host.wr(`VBC_OFF_CFG1_A, 8'h01, 1'b0);
      cyc(2);
      chk("state", st, 10'h106);
      // local reset from port a keeps the fail bit
      u_host.wr(`VBC_OFF_CTRL_A, 8'h0b, 1'b0);
      cyc(4);
      chk("state", st, 10'h260);
      u_host.wr(`VBC_OFF_CTRL_A, 8'h0c, 1'b1);
      cyc(12);
      chk("state", st, 10'h260);
      wait_low();
      chk("state", st, 10'h220);
      // bus reset forces local reset
      @(posedge clk);
      sysrst_n <= 1'b0;
      strap <= 1'b0;
      cyc(3);
      chk("state", st, 10'h240);
      @(posedge clk);
      sysrst_n <= 1'b1;
      wait_low();
      chk("state", st, 10'h200);
      chk("sysfail_out", 10'(sfo), 10'h000);
      finish_test();
   end
endmodule : tb

/* dv/vbc_host_model.sv */
// host model that writes the board registers
`timescale 1ns/100ps
module vbc_host_model
   import vbc_pkg::*;
(
   input wire logic clk,
   output logic reg_wr,
   output logic [9:0] reg_addr,
   output vbc_byte_type reg_wdata,
   output logic reg_supv
);
   // bus idle at time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 10'h000;
      reg_wdata = 8'h00;
      reg_supv = 1'b1;
   end
   // one write; address and data scrambled once released
   task automatic wr(input logic [9:0] a, input vbc_byte_type d, input logic s);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d & 8'h1f;
      reg_supv <= s;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
endmodule : vbc_host_model

/* dv/vbc_sva.sv */
// assertion checker for the board config block, with its bind
`timescale 1ns/100ps
`include "vbc_defs.svh"
module vbc_sva
   import vbc_pkg::*;
#(
   parameter int LMR_HOLD_CYCLES = 16
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic [`VBC_ADDR_W-1:0] REG_ADDR,
   input wire vbc_byte_type REG_WDATA,
   input wire logic REG_SUPV,
   input wire logic SYSRESET_N,
   input wire logic FAIL_LINE_JUMPER,
   input wire logic SYSFAIL_OE,
   input wire logic LED_GREEN,
   input wire logic LED_RED,
   input wire logic LOCAL_RESET,
   input wire logic PRIVILEGE_ACCESS_SELECT,
   input wire logic EXTENDED_ADDRESS_MODE,
   input wire vbc_am_type AM_CODE_A,
   input wire logic BUS_CONTROLLER_ROLE_A,
   input wire logic DIRECTION_A
);
   // high run of the local reset line
   int run_q;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////
   // count cycles the local reset line stays high
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
         run_q <= 0;
      else
         run_q <= LOCAL_RESET ? run_q + 1 : 0;
   end
   // supervisor write setting the fail bit
   sequence fail_set_wr;
      REG_WR && REG_SUPV && REG_ADDR == `VBC_OFF_CTRL_A && REG_WDATA[3];
   endsequence
   // supervisor write clearing the privilege bit
   sequence priv_clr_wr;
      REG_WR && REG_SUPV && REG_ADDR == `VBC_OFF_CTRL_B && !REG_WDATA[2] && !LOCAL_RESET;
   endsequence
   chk_led_pair: assert property (LED_GREEN != LED_RED)
      else $error("led outputs equal");
   chk_fail_led: assert property (SYSFAIL_OE |-> LED_RED)
      else $error("fail line pulled while green");
   chk_fail_jumper: assert property (SYSFAIL_OE |-> $past(FAIL_LINE_JUMPER))
      else $error("fail line pulled without jumper");
   chk_green_write: assert property (fail_set_wr |-> ##2 LED_GREEN && !SYSFAIL_OE)
      else $error("fail bit write not shown");
   chk_ext_top_zero: assert property (EXTENDED_ADDRESS_MODE |-> AM_CODE_A[5:4] == 2'b00)
      else $error("modifier top bits set");
   chk_bus_reset: assert property (!SYSRESET_N |-> ##[1:3] LOCAL_RESET)
      else $error("bus reset ignored");
   chk_lr_hold: assert property ($fell(LOCAL_RESET) |-> run_q >= LMR_HOLD_CYCLES)
      else $error("local reset too short");
   chk_lr_clears: assert property (LOCAL_RESET |-> ##1 !BUS_CONTROLLER_ROLE_A && !DIRECTION_A)
      else $error("port bits kept in local reset");
   chk_priv_write: assert property (priv_clr_wr |-> ##2 !PRIVILEGE_ACCESS_SELECT)
      else $error("privilege bit not cleared");
endmodule : vbc_sva
bind vbc_board_config vbc_sva #(.LMR_HOLD_CYCLES(LMR_HOLD_CYCLES)) u_sva (
   .MCLK(MCLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_SUPV(REG_SUPV), .SYSRESET_N(SYSRESET_N),
   .FAIL_LINE_JUMPER(FAIL_LINE_JUMPER), .SYSFAIL_OE(SYSFAIL_OE), .LED_GREEN(LED_GREEN),
   .LED_RED(LED_RED), .LOCAL_RESET(LOCAL_RESET),
   .PRIVILEGE_ACCESS_SELECT(PRIVILEGE_ACCESS_SELECT),
   .EXTENDED_ADDRESS_MODE(EXTENDED_ADDRESS_MODE), .AM_CODE_A(AM_CODE_A),
   .BUS_CONTROLLER_ROLE_A(BUS_CONTROLLER_ROLE_A), .DIRECTION_A(DIRECTION_A)
);

/* rtl/vbc_board_config.sv */
// board configuration registers for a two-port bus interface board
//
// Function
// - direction bit resets to memory-to-instrument
// - control register at base 0x105 and 0x305
// - control register eight bits, write only
// - extended mode needs bit and jumper
// - standard mode: modifier from codes, jumpers
// - extended mode: modifier top two zero
// - fail bit drives LED; line via jumper
// - fail one: green, line released
// - fail bit clear at power-up
// - local reset leaves fail bit alone
// - reset bit drives local reset, 10 ms
// - controller role bit, cleared on reset
// - privilege bit limits to supervisor cycles
`timescale 1ns/100ps
`include "vbc_defs.svh"

module vbc_board_config
   import vbc_pkg::*;
#(
   parameter int LMR_HOLD_CYCLES = `VBC_LMR_HOLD_CYCLES
)
(
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic [`VBC_ADDR_W-1:0] REG_ADDR,
   input wire vbc_byte_type REG_WDATA,
   input wire logic REG_SUPV,
   input wire logic SYSRESET_N,
   input wire logic EXTENDED_ADDRESS_JUMPER,
   input wire logic FAIL_LINE_JUMPER,
   input wire logic MODIFIER_JUMPER_ONE,
   input wire logic MODIFIER_JUMPER_TWO,
   input wire logic MODIFIER_JUMPER_THREE,
   input wire logic PRIVILEGE_STRAP,
   input wire logic [2:0] FUNC_CODE_A,
   input wire logic [2:0] FUNC_CODE_B,
   output logic SYSFAIL_OUT,
   output logic SYSFAIL_OE,
   output logic LED_GREEN,
   output logic LED_RED,
   output logic LOCAL_RESET,
   output logic PRIVILEGE_ACCESS_SELECT,
   output logic EXTENDED_ADDRESS_MODE,
   output vbc_am_type AM_CODE_A,
   output vbc_am_type AM_CODE_B,
   output logic BUS_CONTROLLER_ROLE_A,
   output logic BUS_CONTROLLER_ROLE_B,
   output logic DIRECTION_A,
   output logic DIRECTION_B
);

   //////////////////////////////////////////////////////////////////////////
   // declarations

   // decoded write strobes, one per port
   logic [1:0] wr_cfg1;
   logic [1:0] wr_ctrl;
   // write passes the privilege check
   logic wr_ok;
   // per-port bits from the port slices
   logic [1:0] dir_bit;
   logic [1:0] role_bit;
   logic [1:0] lmr_bit;
   // any source asking for the local reset
   logic lmr_req;
   // board-wide bits
   logic ext_q;
   logic fail_q;
   logic priv_q;
   // strap for privilege bit taken once after release
   logic strap_done_q;
   // hold counter for the local reset line
   logic [`VBC_HOLD_W-1:0] hold_cnt_q;
   logic local_rst_q;
   // extended mode as used for the modifier code
   logic ext_mode;
   // any control register write, either port
   logic any_ctrl;

   //////////////////////////////////////////////////////////////////////////
   // address match against a printed offset
   function automatic logic addr_hit(input logic [`VBC_ADDR_W-1:0] addr,
                                     input logic [`VBC_ADDR_W-1:0] off);
      addr_hit = (addr == off);
   endfunction : addr_hit

   // modifier code from function codes and jumpers
   function automatic vbc_am_type form_am(input logic ext,
                                          input logic [2:0] fc,
                                          input logic j1,
                                          input logic j2,
                                          input logic j3);
      if (ext)
      begin
         form_am = {2'b00, j1, fc};
      end
      else
      begin
         form_am = {j3, j2, j1, fc};
      end
   endfunction : form_am

   //////////////////////////////////////////////////////////////////////////
   // write qualification and address decode

   // user cycles are refused while supervisor-only is selected
   assign wr_ok = REG_WR & (REG_SUPV | ~priv_q);

   // decode both ports; registers are write only, nothing is read back
   always_comb
   begin
      wr_cfg1 = 2'b00;
      wr_ctrl = 2'b00;
      if (!wr_ok)
      begin
         wr_cfg1 = 2'b00;
      end
      else if (addr_hit(REG_ADDR, `VBC_OFF_CTRL_A))
      begin
         wr_ctrl[VBC_PORT_A] = 1'b1;
      end
      else if (addr_hit(REG_ADDR, `VBC_OFF_CTRL_B))
      begin
         wr_ctrl[VBC_PORT_B] = 1'b1;
      end
      else if (addr_hit(REG_ADDR, `VBC_OFF_CFG1_A))
      begin
         wr_cfg1[VBC_PORT_A] = 1'b1;
      end
      else if (addr_hit(REG_ADDR, `VBC_OFF_CFG1_B))
      begin
         wr_cfg1[VBC_PORT_B] = 1'b1;
      end
      else
      begin
         // unmapped offsets are ignored
         wr_cfg1 = 2'b00;
      end
   end

   // a control register write from either port reaches the board-wide bits
   assign any_ctrl = |wr_ctrl;

   //////////////////////////////////////////////////////////////////////////
   // per-port register slices, separate copies for each port
   genvar gp;
   generate
      for (gp = 0; gp < 2; gp++)
      begin : g_port
         vbc_port_regs u_port (
            .clk(MCLK),
            .rst_n(RST_N),
            .wr_cfg1(wr_cfg1[gp]),
            .wr_ctrl(wr_ctrl[gp]),
            .wdata(REG_WDATA),
            .local_rst(local_rst_q),
            .dir_q(dir_bit[gp]),
            .role_q(role_bit[gp]),
            .lmr_q(lmr_bit[gp])
         );
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////
   // local reset line with least hold time

   // either port's reset bit or the system bus reset asks for it
   assign lmr_req = (|lmr_bit) | ~SYSRESET_N;

   // reload while requested, then count the remaining hold time down
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         hold_cnt_q <= '0;
      end
      else if (lmr_req)
      begin
         hold_cnt_q <= LMR_HOLD_CYCLES[`VBC_HOLD_W-1:0];
      end
      else if (hold_cnt_q != '0)
      begin
         hold_cnt_q <= hold_cnt_q - 1'b1;
      end
   end

   // line stays active while requested or the hold is running
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         local_rst_q <= 1'b0;
      end
      else
      begin
         local_rst_q <= lmr_req | (hold_cnt_q != '0);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // board-wide bits

   // extended address bit; bits 7..5 are ignored, host keeps them zero
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ext_q <= `VBC_EXT_RST;
      end
      else if (local_rst_q)
      begin
         ext_q <= `VBC_EXT_RST;
      end
      else if (any_ctrl)
      begin
         ext_q <= REG_WDATA[`VBC_EXT_BIT];
      end
   end

   // fail bit: cleared at power-up or by a control write, never by the local reset
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         fail_q <= `VBC_FAIL_RST;
      end
      else if (any_ctrl)
      begin
         fail_q <= REG_WDATA[`VBC_FAIL_BIT];
      end
   end

   // privilege bit: strap taken after release and on local reset
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         strap_done_q <= 1'b0;
         priv_q <= 1'b1;
      end
      else if (!strap_done_q || local_rst_q)
      begin
         strap_done_q <= 1'b1;
         priv_q <= PRIVILEGE_STRAP;
      end
      else if (any_ctrl)
      begin
         priv_q <= REG_WDATA[`VBC_PRIV_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // address mode and modifier codes

   // both the bit and the jumper must ask for extended mode
   assign ext_mode = ext_q & EXTENDED_ADDRESS_JUMPER;

   // registered modifier codes, one per port
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         EXTENDED_ADDRESS_MODE <= 1'b0;
         AM_CODE_A <= '0;
         AM_CODE_B <= '0;
      end
      else
      begin
         EXTENDED_ADDRESS_MODE <= ext_mode;
         AM_CODE_A <= form_am(ext_mode, FUNC_CODE_A, MODIFIER_JUMPER_ONE,
                              MODIFIER_JUMPER_TWO, MODIFIER_JUMPER_THREE);
         AM_CODE_B <= form_am(ext_mode, FUNC_CODE_B, MODIFIER_JUMPER_ONE,
                              MODIFIER_JUMPER_TWO, MODIFIER_JUMPER_THREE);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // fail indication: LED colour and open-drain fail line
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         LED_GREEN <= 1'b0;
         LED_RED <= 1'b1;
         SYSFAIL_OE <= 1'b0;
         SYSFAIL_OUT <= 1'b0;
      end
      else
      begin
         LED_GREEN <= fail_q;
         LED_RED <= ~fail_q;
         // pulled low only while failing and the jumper allows it
         SYSFAIL_OE <= ~fail_q & FAIL_LINE_JUMPER;
         SYSFAIL_OUT <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // remaining status outputs
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         LOCAL_RESET <= 1'b0;
         PRIVILEGE_ACCESS_SELECT <= 1'b1;
         BUS_CONTROLLER_ROLE_A <= 1'b0;
         BUS_CONTROLLER_ROLE_B <= 1'b0;
         DIRECTION_A <= 1'b0;
         DIRECTION_B <= 1'b0;
      end
      else
      begin
         LOCAL_RESET <= local_rst_q;
         PRIVILEGE_ACCESS_SELECT <= priv_q;
         BUS_CONTROLLER_ROLE_A <= role_bit[VBC_PORT_A];
         BUS_CONTROLLER_ROLE_B <= role_bit[VBC_PORT_B];
         DIRECTION_A <= dir_bit[VBC_PORT_A];
         DIRECTION_B <= dir_bit[VBC_PORT_B];
      end
   end

endmodule : vbc_board_config

/* rtl/vbc_defs.svh */
// offsets, bit positions, reset values and timing counts of the board config block
`ifndef VBC_DEFS_SVH
`define VBC_DEFS_SVH

// register offsets from the board base, as decoded on the address port
`define VBC_ADDR_W 10
`define VBC_OFF_CFG1_A 10'h101
`define VBC_OFF_CTRL_A 10'h105
`define VBC_OFF_CFG1_B 10'h301
`define VBC_OFF_CTRL_B 10'h305

// first configuration register: only the direction bit is kept
`define VBC_DIR_BIT 0
`define VBC_DIR_RST 1'b0

// board control register fields
`define VBC_EXT_BIT 4
`define VBC_FAIL_BIT 3
`define VBC_PRIV_BIT 2
`define VBC_LMR_BIT 1
`define VBC_ROLE_BIT 0
`define VBC_EXT_RST 1'b0
`define VBC_FAIL_RST 1'b0
`define VBC_LMR_RST 1'b0
`define VBC_ROLE_RST 1'b0

// local reset least hold time and clock rate
`define VBC_LMR_HOLD_MS 10
`define VBC_CLK_KHZ 50000
`define VBC_LMR_HOLD_CYCLES (`VBC_LMR_HOLD_MS * `VBC_CLK_KHZ)
`define VBC_HOLD_W 20

`endif

/* rtl/vbc_pkg.sv */
// types shared by the board config block
package vbc_pkg;

   // one register byte as written by the host
   typedef logic [7:0] vbc_byte_type;

   // address modifier code driven with each bus cycle
   typedef logic [5:0] vbc_am_type;

   // which instrument port a register belongs to
   typedef enum {VBC_PORT_A, VBC_PORT_B} vbc_port_type;

endpackage : vbc_pkg

/* rtl/vbc_port_regs.sv */
// per-port configuration bits: direction, controller role, local reset request
`timescale 1ns/100ps
`include "vbc_defs.svh"

module vbc_port_regs
   import vbc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_cfg1,
   input wire logic wr_ctrl,
   input wire vbc_byte_type wdata,
   input wire logic local_rst,
   output logic dir_q,
   output logic role_q,
   output logic lmr_q
);

   //////////////////////////////////////////////////////////////////////////
   // direction bit, cleared at power-up and by the board reset line
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dir_q <= `VBC_DIR_RST;
      end
      else if (local_rst)
      begin
         dir_q <= `VBC_DIR_RST;
      end
      else if (wr_cfg1)
      begin
         dir_q <= wdata[`VBC_DIR_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // controller role bit, cleared at power-up and by the board reset line
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         role_q <= `VBC_ROLE_RST;
      end
      else if (local_rst)
      begin
         role_q <= `VBC_ROLE_RST;
      end
      else if (wr_ctrl)
      begin
         role_q <= wdata[`VBC_ROLE_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // local reset request; kept through the local reset so software can drop it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lmr_q <= `VBC_LMR_RST;
      end
      else if (wr_ctrl)
      begin
         lmr_q <= wdata[`VBC_LMR_BIT];
      end
   end

endmodule : vbc_port_regs
